// file: design/fcd_host.sv
// Contract
// - All command cycles are writes, except array and identification reads.
// - Single F0 write is reset; leaves identification mode or timeout failure.
// - Identification entry: AA, 55, 90 at unlock addresses, then a read.
// - Program: two unlocks, A0, then value at target address.
// - Sector erase: unlocks, 80, unlocks, 30 at sector address.
// - Host polls at the address being programmed.
// - Host polls erase inside a selected sector.
// - After polling bit turns true, take data from the next read.
// - Recheck polling bit after seeing the timeout flag.
// - Chip erase: unlocks, 80, unlocks, 10.
`timescale 1ns/1ps
module fcd_host #(
  parameter int POLL_LIMIT = 1000000
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             flash_ce_n,
  output logic                             flash_we_n,
  output logic                             flash_oe_n,
  output logic      [fcd_pkg::ADDR_W-1:0]  flash_addr,
  output logic      [fcd_pkg::DATA_W-1:0]  flash_dq_out,
  output logic                             flash_dq_oe,
  input  wire logic [fcd_pkg::DATA_W-1:0]  flash_dq_in,
  output logic                             flash_reset_n,
  input  wire logic                        ready_busy_out
);
  typedef enum logic [2:0] {S_IDLE, S_HWRST, S_HWREC, S_WR, S_RD, S_POLL, S_FINAL, S_ABORT} fcd_state_e;

  fcd_state_e                  st, next_st;
  logic [2:0]                  step, next_step;
  logic                        issued, next_issued;
  logic [31:0]                 poll_cnt, next_poll_cnt;
  logic [7:0]                  tmr, next_tmr;
  logic                        tmo_seen, next_tmo_seen;
  logic                        done_f, next_done_f, fail_f, next_fail_f;
  logic                        next_reset_n;
  logic [3:0]                  op, next_op;
  logic                        byte_mode;
  logic [fcd_pkg::ADDR_W-1:0]  target;
  logic [fcd_pkg::DATA_W-1:0]  wval, result, next_result;
  logic                        rb_meta, rb_sync;
  logic                        eng_start, eng_write, eng_done;
  logic [fcd_pkg::ADDR_W-1:0]  eng_addr;
  logic [fcd_pkg::DATA_W-1:0]  eng_data, eng_rdata;
  logic                        wr_acc, cmd_go, addr_ok;
  logic [31:0]                 next_prdata;

  // Write cycles each operation needs before its read or poll phase
  function automatic logic [2:0] n_writes(input logic [3:0] o);
    case (o)
      fcd_pkg::OP_AUTOSEL: return 3'd3;
      fcd_pkg::OP_PROGRAM: return 3'd4;
      fcd_pkg::OP_CHIP, fcd_pkg::OP_SECTOR: return 3'd6;
      fcd_pkg::OP_RESET, fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME: return 3'd1;
      default: return 3'd0;
    endcase
  endfunction : n_writes

  // Address of one command cycle; unlock addresses keep bits 18..12 at zero
  function automatic logic [fcd_pkg::ADDR_W-1:0] seq_addr(input logic [3:0] o, input logic [2:0] s,
                                                         input logic bm, input logic [fcd_pkg::ADDR_W-1:0] t);
    logic single;
    single = (o == fcd_pkg::OP_RESET) || (o == fcd_pkg::OP_SUSPEND) || (o == fcd_pkg::OP_RESUME);
    if (single) return fcd_pkg::A_ANY;
    if ((o == fcd_pkg::OP_PROGRAM && s == 3'd3) || (o == fcd_pkg::OP_SECTOR && s == 3'd5)) return t;
    if (s == 3'd1 || s == 3'd4) return bm ? fcd_pkg::A_BYTE2 : fcd_pkg::A_WORD2;
    return bm ? fcd_pkg::A_BYTE1 : fcd_pkg::A_WORD1;
  endfunction : seq_addr

  // Data of one command cycle; upper byte driven zero except program value
  function automatic logic [fcd_pkg::DATA_W-1:0] seq_data(input logic [3:0] o, input logic [2:0] s,
                                                         input logic [fcd_pkg::DATA_W-1:0] v);
    logic [7:0] d;
    case (o)
      fcd_pkg::OP_RESET:   d = fcd_pkg::D_RESET;
      fcd_pkg::OP_SUSPEND: d = fcd_pkg::D_SUSPEND;
      fcd_pkg::OP_RESUME:  d = fcd_pkg::D_RESUME;
      default: begin
        case (s)
          3'd0, 3'd3: d = fcd_pkg::D_UNLOCK1;
          3'd1, 3'd4: d = fcd_pkg::D_UNLOCK2;
          // Identification, program or erase setup code
          3'd2: d = (o == fcd_pkg::OP_AUTOSEL) ? fcd_pkg::D_AUTOSEL :
                    (o == fcd_pkg::OP_PROGRAM) ? fcd_pkg::D_PROGRAM : fcd_pkg::D_SETUP;
          default: d = (o == fcd_pkg::OP_SECTOR) ? fcd_pkg::D_SECTOR : fcd_pkg::D_CHIP;
        endcase
      end
    endcase
    if (o == fcd_pkg::OP_PROGRAM && s == 3'd3) return v;
    return {8'h00, d};
  endfunction : seq_data

  // APB register file; zero wait states
  assign pready  = 1'b1;
  assign addr_ok = (paddr == fcd_pkg::REG_CMD) || (paddr == fcd_pkg::REG_ADDR) ||
                   (paddr == fcd_pkg::REG_WDATA) || (paddr == fcd_pkg::REG_RDATA) ||
                   (paddr == fcd_pkg::REG_STATUS) || (paddr == fcd_pkg::REG_CONFIG);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_acc  = psel & penable & pwrite & addr_ok;
  // New command taken only while idle; others are dropped silently
  assign cmd_go  = wr_acc && (paddr == fcd_pkg::REG_CMD) && (st == S_IDLE);

  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      case (paddr)
        fcd_pkg::REG_CMD:    next_prdata = {28'h0000000, op};
        fcd_pkg::REG_ADDR:   next_prdata = {13'h0000, target};
        fcd_pkg::REG_WDATA:  next_prdata = {16'h0000, wval};
        fcd_pkg::REG_RDATA:  next_prdata = {16'h0000, result};
        fcd_pkg::REG_STATUS: next_prdata = {27'h0000000, tmo_seen, rb_sync, fail_f, done_f, st != S_IDLE};
        fcd_pkg::REG_CONFIG: next_prdata = {31'h00000000, byte_mode};
        default:             next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000; target <= 19'h00000; wval <= 16'h0000; byte_mode <= 1'b0;
      rb_meta <= 1'b0; rb_sync <= 1'b0;
    end else begin
      prdata <= next_prdata;
      if (wr_acc && paddr == fcd_pkg::REG_ADDR && st == S_IDLE) target <= pwdata[fcd_pkg::ADDR_W-1:0];
      if (wr_acc && paddr == fcd_pkg::REG_WDATA && st == S_IDLE) wval <= pwdata[fcd_pkg::DATA_W-1:0];
      if (wr_acc && paddr == fcd_pkg::REG_CONFIG && st == S_IDLE) byte_mode <= pwdata[fcd_pkg::CFG_BYTE];
      // Busy pin seen through two flops
      rb_meta <= ready_busy_out;
      rb_sync <= rb_meta;
    end
  end

  // Sequencer
  always_comb begin
    next_st = st; next_step = step; next_issued = issued; next_poll_cnt = poll_cnt;
    next_tmr = tmr; next_tmo_seen = tmo_seen; next_done_f = done_f; next_fail_f = fail_f;
    next_reset_n = flash_reset_n; next_op = op; next_result = result;
    eng_start = 1'b0; eng_write = 1'b0;
    eng_addr = target; eng_data = wval;
    case (st)
      S_IDLE: begin
        if (cmd_go) begin
          next_op = pwdata[3:0]; next_step = 3'd0; next_issued = 1'b0; next_poll_cnt = 32'h00000000;
          next_tmo_seen = 1'b0; next_done_f = 1'b0; next_fail_f = 1'b0;
          if (pwdata[3:0] == fcd_pkg::OP_HWRESET) begin
            next_st = S_HWRST; next_reset_n = 1'b0; next_tmr = 8'(fcd_pkg::RP_CYC - 1);
          end else begin
            // Plain array read needs no command cycles
            next_st = (n_writes(pwdata[3:0]) == 3'd0) ? S_RD : S_WR;
          end
        end
      end
      S_HWRST: begin
        if (tmr != 8'h00) next_tmr = tmr - 8'h01;
        else begin
          next_st = S_HWREC; next_reset_n = 1'b1; next_tmr = 8'(fcd_pkg::RH_CYC - 1);
        end
      end
      S_HWREC: begin
        if (tmr != 8'h00) next_tmr = tmr - 8'h01;
        else begin
          next_st = S_IDLE; next_done_f = 1'b1;
        end
      end
      S_WR: begin
        eng_start = ~issued; eng_write = 1'b1; next_issued = 1'b1;
        eng_addr = seq_addr(op, step, byte_mode, target);
        eng_data = seq_data(op, step, wval);
        if (eng_done) begin
          next_issued = 1'b0; next_step = step + 3'd1;
          if (step + 3'd1 == n_writes(op)) begin
            case (op)
              fcd_pkg::OP_AUTOSEL: next_st = S_RD;
              fcd_pkg::OP_PROGRAM, fcd_pkg::OP_CHIP, fcd_pkg::OP_SECTOR: next_st = S_POLL;
              default: begin
                next_st = S_IDLE; next_done_f = 1'b1;
              end
            endcase
          end
        end
      end
      S_RD, S_FINAL: begin
        // Fourth cycle of identification is a read
        eng_start = ~issued; next_issued = 1'b1;
        if (eng_done) begin
          next_issued = 1'b0; next_result = eng_rdata; next_st = S_IDLE; next_done_f = 1'b1;
        end
      end
      S_POLL: begin
        eng_start = ~issued; next_issued = 1'b1;
        if (eng_done) begin
          next_issued = 1'b0; next_result = eng_rdata; next_poll_cnt = poll_cnt + 32'h00000001;
          if (eng_rdata[fcd_pkg::POLL_BIT] == ((op == fcd_pkg::OP_PROGRAM) ? wval[fcd_pkg::POLL_BIT] : 1'b1)) begin
            // Take data only from the next read
            next_st = S_FINAL;
          end else if (tmo_seen || poll_cnt + 32'h00000001 >= 32'(POLL_LIMIT)) begin
            next_st = S_ABORT; next_fail_f = 1'b1; next_step = 3'd0;
          end else if (eng_rdata[fcd_pkg::TMO_BIT]) begin
            // One more look once the timeout flag shows
            next_tmo_seen = 1'b1;
          end
        end
      end
      S_ABORT: begin
        eng_start = ~issued; eng_write = 1'b1; next_issued = 1'b1;
        eng_addr = fcd_pkg::A_ANY; eng_data = {8'h00, fcd_pkg::D_RESET};
        if (eng_done) begin
          next_issued = 1'b0; next_st = S_IDLE; next_done_f = 1'b1;
        end
      end
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE; step <= 3'd0; issued <= 1'b0; poll_cnt <= 32'h00000000; tmr <= 8'h00;
      tmo_seen <= 1'b0; done_f <= 1'b0; fail_f <= 1'b0; flash_reset_n <= 1'b1;
      op <= fcd_pkg::OP_READ; result <= 16'h0000;
    end else begin
      st <= next_st; step <= next_step; issued <= next_issued; poll_cnt <= next_poll_cnt;
      tmr <= next_tmr; tmo_seen <= next_tmo_seen; done_f <= next_done_f; fail_f <= next_fail_f;
      flash_reset_n <= next_reset_n; op <= next_op; result <= next_result;
    end
  end

  fcd_bus_cycle u_cycle (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (eng_start),
    .is_write     (eng_write),
    .addr_in      (eng_addr),
    .data_in      (eng_data),
    .done         (eng_done),
    .rdata        (eng_rdata),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in)
  );
endmodule : fcd_host

// file: design/fcd_pkg.sv
// Shared constants for the flash command host controller
package fcd_pkg;
  localparam int CLK_MHZ = 40;
  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 16;

  // Least time in ns to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam int T_SETUP_NS  = 25;
  localparam int T_STROBE_NS = 120;
  localparam int T_HOLD_NS   = 25;
  localparam int T_RP_NS     = 500;
  localparam int T_RH_NS     = 50;
  localparam int SETUP_CYC   = cyc_min(T_SETUP_NS);
  localparam int STROBE_CYC  = cyc_min(T_STROBE_NS);
  localparam int HOLD_CYC    = cyc_min(T_HOLD_NS);
  localparam int RP_CYC      = cyc_min(T_RP_NS);
  localparam int RH_CYC      = cyc_min(T_RH_NS);

  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;

  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_RESET   = 4'h1;
  localparam logic [3:0] OP_AUTOSEL = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_CHIP    = 4'h4;
  localparam logic [3:0] OP_SECTOR  = 4'h5;
  localparam logic [3:0] OP_SUSPEND = 4'h6;
  localparam logic [3:0] OP_RESUME  = 4'h7;
  localparam logic [3:0] OP_HWRESET = 4'h8;

  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_AUTOSEL = 8'h90;
  localparam logic [7:0] D_PROGRAM = 8'hA0;
  localparam logic [7:0] D_SETUP   = 8'h80;
  localparam logic [7:0] D_CHIP    = 8'h10;
  localparam logic [7:0] D_SECTOR  = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hB0;
  localparam logic [7:0] D_RESUME  = 8'h30;
  localparam logic [7:0] D_RESET   = 8'hF0;

  localparam logic [ADDR_W-1:0] A_WORD1 = 19'h00555;
  localparam logic [ADDR_W-1:0] A_WORD2 = 19'h002AA;
  localparam logic [ADDR_W-1:0] A_BYTE1 = 19'h00AAA;
  localparam logic [ADDR_W-1:0] A_BYTE2 = 19'h00555;
  localparam logic [ADDR_W-1:0] A_ANY   = 19'h00000;

  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_FAIL  = 2;
  localparam int ST_READY = 3;
  localparam int ST_TMO   = 4;
  localparam int CFG_BYTE = 0;
  localparam int POLL_BIT = 7;
  localparam int TMO_BIT  = 5;
endpackage : fcd_pkg

// file: design/fcd_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, from fixed timing counts
`timescale 1ns/1ps
module fcd_bus_cycle (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        start,
  input  wire logic                        is_write,
  input  wire logic [fcd_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [fcd_pkg::DATA_W-1:0]  data_in,
  output logic                             done,
  output logic      [fcd_pkg::DATA_W-1:0]  rdata,
  output logic                             flash_ce_n,
  output logic                             flash_we_n,
  output logic                             flash_oe_n,
  output logic      [fcd_pkg::ADDR_W-1:0]  flash_addr,
  output logic      [fcd_pkg::DATA_W-1:0]  flash_dq_out,
  output logic                             flash_dq_oe,
  input  wire logic [fcd_pkg::DATA_W-1:0]  flash_dq_in
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fcd_eng_e;
  fcd_eng_e                     st, next_st;
  logic [7:0]                   cnt, next_cnt;
  logic                         wr, next_wr;
  logic                         next_done, next_ce_n, next_we_n, next_oe_n, next_dq_oe;
  logic [fcd_pkg::ADDR_W-1:0]   next_addr;
  logic [fcd_pkg::DATA_W-1:0]   next_dq_out, next_rdata;
  logic [fcd_pkg::DATA_W-1:0]   dq_meta, dq_sync;

  always_comb begin
    next_st = st; next_cnt = cnt; next_wr = wr; next_done = 1'b0;
    next_ce_n = flash_ce_n; next_we_n = flash_we_n; next_oe_n = flash_oe_n;
    next_dq_oe = flash_dq_oe; next_addr = flash_addr; next_dq_out = flash_dq_out;
    next_rdata = rdata;
    if (cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end else begin
      case (st)
        E_IDLE: begin
          if (start) begin
            next_st = E_SETUP; next_cnt = 8'(fcd_pkg::SETUP_CYC - 1);
            next_wr = is_write; next_ce_n = 1'b0; next_addr = addr_in;
            next_dq_out = data_in; next_dq_oe = is_write;
          end
        end
        E_SETUP: begin
          next_st = E_STROBE; next_cnt = 8'(fcd_pkg::STROBE_CYC - 1);
          next_we_n = ~wr; next_oe_n = wr;
        end
        E_STROBE: begin
          next_st = E_HOLD; next_cnt = 8'(fcd_pkg::HOLD_CYC - 1);
          next_we_n = 1'b1; next_oe_n = 1'b1;
          if (!wr) next_rdata = dq_sync;
        end
        E_HOLD: begin
          next_st = E_IDLE; next_ce_n = 1'b1; next_dq_oe = 1'b0; next_done = 1'b1;
        end
        default: next_st = E_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= E_IDLE; cnt <= 8'h00; wr <= 1'b0; done <= 1'b0; rdata <= 16'h0000;
      flash_ce_n <= 1'b1; flash_we_n <= 1'b1; flash_oe_n <= 1'b1; flash_dq_oe <= 1'b0;
      flash_addr <= 19'h00000; flash_dq_out <= 16'h0000; dq_meta <= 16'h0000; dq_sync <= 16'h0000;
    end else begin
      st <= next_st; cnt <= next_cnt; wr <= next_wr; done <= next_done; rdata <= next_rdata;
      flash_ce_n <= next_ce_n; flash_we_n <= next_we_n; flash_oe_n <= next_oe_n;
      flash_dq_oe <= next_dq_oe; flash_addr <= next_addr; flash_dq_out <= next_dq_out;
      // Pins come from outside the clock domain
      dq_meta <= flash_dq_in; dq_sync <= dq_meta;
    end
  end
endmodule : fcd_bus_cycle

// file: bench/fcd_flash_model.sv
// Behavioural flash device facing the host
`timescale 1ns/1ps
module fcd_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h0000,  // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0000   // Arbitrary value
) (
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic [18:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_reset_n,
  input  wire logic        byte_mode,
  output logic      [15:0] flash_dq_in,
  output logic             ready_busy_out,
  output logic      [7:0]  seq_errs = 8'h00
);
  logic [15:0] mem [16] = '{default: 16'hFFFF};
  logic [15:0] last = 16'h0000;
  logic [15:0] pv;
  logic [18:0] la, u1, u2;
  logic [7:0]  d;
  logic        auto = 1'b0;
  logic        prog = 1'b0;
  logic        tmo = 1'b0;
  int          step = 0;
  int          busy = 0;
  assign u1 = byte_mode ? 19'h00AAA : 19'h00555;
  assign u2 = byte_mode ? 19'h00555 : 19'h002AA;
  assign ready_busy_out = (busy == 0);
  // Released bus shows the inverse, so a stale sample never matches by luck
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? last : ~last;
  always @(negedge flash_reset_n) begin
    step = 0;
    busy = 0;
    auto = 1'b0;
    tmo = 1'b0;
  end
  always @(negedge flash_we_n) la = flash_addr;
  always @(posedge flash_we_n) if (!flash_ce_n && flash_reset_n) begin
    d = flash_dq_out[7:0];
    // only a reset write or a fall of the reset pin leaves the timeout state
    if (tmo) begin
      tmo = d != 8'hF0;
      busy = tmo ? busy : 0;
    end else if (busy == 0) begin
      // single writes; suspend and resume idle outside erase
      if (step == 0 && (d == 8'hF0 || d == 8'hB0 || d == 8'h30)) auto = auto && d != 8'hF0;
      else case (step)
        0, 3: step = (d == 8'hAA && la[10:0] == u1[10:0]) ? step + 1 : -1;
        1, 4: step = (d == 8'h55 && la[10:0] == u2[10:0]) ? step + 1 : -1;
        2: step = (la[10:0] != u1[10:0]) ? -1 : (d == 8'h90) ? 7 : (d == 8'hA0) ? 6 : (d == 8'h80) ? 3 : -1;
        5: if (d == 8'h10 || d == 8'h30) begin
          mem = '{default: 16'hFFFF};
          prog = 1'b0;
          busy = 3;
          step = 0;
        end else step = -1;
        6: begin
          pv = flash_dq_out;
          prog = 1'b1;
          busy = (la[18:12] == 7'h7F) ? 2 : 3;
          // raising a cleared bit never completes
          tmo = busy == 3 && (mem[la[3:0]] | pv) != mem[la[3:0]];
          if (busy == 3) mem[la[3:0]] &= pv;
          step = 0;
        end
        default: step = -1;
      endcase
      auto = (step == 7) || (auto && step >= 0);
      if (step < 0) seq_errs++;
      step = (step < 0 || step == 7) ? 0 : step;
    end
  end
  always @(negedge flash_oe_n) if (!flash_ce_n) begin
    if (busy > 0) begin
      last = prog ? {8'h00, ~pv[7], 1'b0, tmo, 5'h00} : 16'h0000;
      if (!tmo) busy--;
    end else if (auto) begin
      last = (flash_addr[7:0] == 8'h00) ? MAKER_ID : (flash_addr[7:0] == (byte_mode ? 8'h02 : 8'h01)) ? PART_ID
        : {15'h0000, flash_addr[18:12] == 7'h7F};
    end else last = mem[flash_addr[3:0]];
  end
endmodule : fcd_flash_model

// file: bench/fcd_host_chk.sv
// Flash pin checker for the command host
`timescale 1ns/1ps
module fcd_host_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_reset_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("Read and write strobes low together");
  a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("Write strobe without select or data drive");
  a_read_float: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
    else $error("Read strobe without select or with data drive");
  a_ce_setup: assert property ($fell(flash_ce_n) |-> flash_we_n && flash_oe_n ##1 (!flash_we_n || !flash_oe_n))
    else $error("Select setup cycle missing");
  a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
    else $error("Write strobe width wrong");
  a_we_hold: assert property ($rose(flash_we_n) |-> !flash_ce_n && $stable(flash_dq_out) ##1 flash_ce_n)
    else $error("Data hold after write strobe wrong");
  a_addr_hold: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("Address moved inside a bus cycle");
  a_cmd_upper: assert property (!flash_we_n && flash_dq_out[7:0] == 8'hAA |-> flash_dq_out[15:8] == 8'h00)
    else $error("Unlock cycle upper byte not zero");
  a_rst_width: assert property ($fell(flash_reset_n) |-> ##19 !flash_reset_n ##1 flash_reset_n)
    else $error("Reset pulse width wrong");
  c_hw_reset: cover property ($fell(flash_reset_n));
  c_read: cover property ($fell(flash_oe_n));
  c_program: cover property (!flash_we_n && flash_dq_out[7:0] == 8'hA0);
endmodule : fcd_host_chk

// file: bench/tb.sv
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] MAKER_ID = 16'h00C3;  // Arbitrary value
  localparam logic [15:0] PART_ID  = 16'h4D21;  // Arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, flash_reset_n, ready_busy_out, byte_mode;
  logic [7:0]  paddr, seq_errs;
  logic [31:0] pwdata, prdata, rd, er;
  logic [18:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int          fail_count, comparisons;
  fcd_host #(.POLL_LIMIT(16)) fcd_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_out, .flash_dq_oe,
    .flash_dq_in, .flash_reset_n, .ready_busy_out);
  fcd_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) fcd_flash_model_i (.flash_ce_n, .flash_we_n,
    .flash_oe_n, .flash_addr, .flash_dq_out, .flash_reset_n, .byte_mode, .flash_dq_in, .ready_busy_out, .seq_errs);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Busy commands are dropped, so every operation waits for idle status
  task automatic run(input logic [3:0] c, input logic [18:0] a, input logic [15:0] d,
                     input logic [31:0] est = 32'h0000000A);
    int n = 0;
    apb(1'b1, fcd_pkg::REG_ADDR, {13'h0, a});
    apb(1'b1, fcd_pkg::REG_WDATA, {16'h0, d});
    apb(1'b1, fcd_pkg::REG_CMD, {28'h0, c});
    do apb(1'b0, fcd_pkg::REG_STATUS, 32'h0); while (rd[fcd_pkg::ST_BUSY] !== 1'b0 && ++n < 400);
    cmp(rd, est);
  endtask : run
  task automatic rdat(input logic [15:0] exp);
    apb(1'b0, fcd_pkg::REG_RDATA, 32'h0);
    cmp(rd, {16'h0, exp});
  endtask : rdat
  task automatic print_verdict();
    $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    byte_mode = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Busy pin reaches status through two flops
    repeat (2) @(posedge pclk);
    apb(1'b0, fcd_pkg::REG_STATUS, 32'h0);
    cmp(rd, 32'h00000008);
    apb(1'b0, 8'h40, 32'h0);
    cmp(er, 32'h00000001);
    cmp(rd, 32'h00000000);
    run(fcd_pkg::OP_PROGRAM, 19'h12345, 16'hA55A);
    rdat(16'hA55A);
    run(fcd_pkg::OP_AUTOSEL, 19'h00000, 16'h0000);
    rdat(MAKER_ID);
    run(fcd_pkg::OP_READ, 19'h00001, 16'h0000);
    rdat(PART_ID);
    run(fcd_pkg::OP_READ, 19'h7F002, 16'h0000);
    rdat(16'h0001);
    run(fcd_pkg::OP_RESET, 19'h00000, 16'h0000);
    run(fcd_pkg::OP_READ, 19'h12345, 16'h0000);
    rdat(16'hA55A);
    run(fcd_pkg::OP_PROGRAM, 19'h12345, 16'h00FF, 32'h0000001E);
    rdat(16'h0020);
    run(fcd_pkg::OP_SUSPEND, 19'h00000, 16'h0000);
    run(fcd_pkg::OP_RESUME, 19'h00000, 16'h0000);
    apb(1'b1, fcd_pkg::REG_CONFIG, 32'h00000001);
    byte_mode <= 1'b1;
    run(fcd_pkg::OP_PROGRAM, 19'h00456, 16'h0033);
    rdat(16'h0033);
    apb(1'b1, fcd_pkg::REG_CONFIG, 32'h0);
    byte_mode <= 1'b0;
    run(fcd_pkg::OP_PROGRAM, 19'h7F010, 16'h00F0);
    rdat(16'hFFFF);
    run(fcd_pkg::OP_SECTOR, 19'h12000, 16'h0000);
    run(fcd_pkg::OP_READ, 19'h12345, 16'h0000);
    rdat(16'hFFFF);
    run(fcd_pkg::OP_CHIP, 19'h00456, 16'h0000);
    rdat(16'hFFFF);
    run(fcd_pkg::OP_HWRESET, 19'h00000, 16'h0000);
    cmp({24'h0, seq_errs}, 32'h0);
    print_verdict();
  end
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
endmodule : tb
bind fcd_host fcd_host_chk fcd_host_chk_i (.pclk, .presetn, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr,
  .flash_dq_out, .flash_dq_oe, .flash_reset_n);
